// ---- logic/ppr_remap.sv ----
// peripheral pin remap unit with ahb-lite register slave
`include "ppr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ppr_remap
  import ppr_pkg::*;
#(
  parameter int NUM_PINS = 26,
  parameter int NUM_IN = 25
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic one_way_lock_option,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] port_out,
  input wire logic [NUM_PINS-1:0] pin_direction_reg,
  input wire logic [31:0] periph_out,
  output logic [NUM_IN-1:0] periph_in,
  output logic map_write_lock,
  output logic cfg_mismatch_reset
);
  localparam logic [5:0] NIN6 = 6'(NUM_IN);
  localparam logic [5:0] NPIN6 = 6'(NUM_PINS);
  localparam logic [4:0] NPIN5 = 5'(NUM_PINS);

  generate
    if (NUM_PINS < 1 || NUM_PINS > `PPR_MAX_PINS) begin : g_bad_pins
      $error("NUM_PINS out of range");
    end
    if (NUM_IN < 1 || NUM_IN > `PPR_MAX_INPUTS) begin : g_bad_inputs
      $error("NUM_IN out of range");
    end
  endgenerate

  ppr_aphase_t ap_d, ap_q;
  ppr_unlock_t ul_state_q;
  logic rd_done_q;
  logic lock_q;
  logic [1:0] one_way_sync_q;
  logic [NUM_PINS-1:0] pin_meta_q, pin_sync_q;
  logic [4:0] in_map_q [NUM_IN];
  logic [4:0] in_shadow_q [NUM_IN];
  logic [4:0] out_map_q [NUM_PINS];
  logic [4:0] out_shadow_q [NUM_PINS];
  logic wr_dphase, wr_osc, wr_in, wr_out;
  logic [31:0] rd_mux;
  logic [4:0] wr_field;
  logic [7:0] wr_low;
  logic mismatch;

  // bus address phase
  always_comb begin
    ap_d = '0;
    if (hsel && htrans[1] && haddr[31:12] == 20'h0 && haddr[1:0] == 2'b00) begin
      ap_d.region = haddr[11:8];
      ap_d.idx = haddr[7:2];
      ap_d.wr = hwrite;
      ap_d.rd = !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else if (hready) begin
      ap_q <= ap_d;
    end
  end

  // one wait state on reads so hrdata always comes from a flop
  always_comb begin
    hreadyout = !(ap_q.rd && !rd_done_q);
    hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= ap_q.rd && !rd_done_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (ap_q.region)
      `PPR_REGION_OSC: begin
        if (ap_q.idx == 6'h0) begin
          rd_mux[`PPR_OSC_LOCK_BIT] = lock_q;
        end
      end
      `PPR_REGION_IN: begin
        if (ap_q.idx < NIN6) begin
          rd_mux[4:0] = in_map_q[ap_q.idx[4:0]];
        end
      end
      `PPR_REGION_OUT: begin
        if (ap_q.idx < NPIN6) begin
          rd_mux[4:0] = out_map_q[ap_q.idx[4:0]];
        end
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ap_q.rd && !rd_done_q) begin
      hrdata <= rd_mux;
    end
  end

  // write data phase decode
  always_comb begin
    wr_dphase = ap_q.wr && hready;
    wr_osc = wr_dphase && ap_q.region == `PPR_REGION_OSC && ap_q.idx == 6'h0;
    wr_in = wr_dphase && ap_q.region == `PPR_REGION_IN && ap_q.idx < NIN6;
    wr_out = wr_dphase && ap_q.region == `PPR_REGION_OUT && ap_q.idx < NPIN6;
    wr_field = hwdata[4:0];
    wr_low = hwdata[7:0];
  end

  // option strap is a pin, so two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      one_way_sync_q <= 2'b00;
    end else begin
      one_way_sync_q <= {one_way_sync_q[0], one_way_lock_option};
    end
  end

  // unlock key sequence; any write in between starts over
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ul_state_q <= PPR_UL_IDLE;
    end else if (wr_dphase) begin
      case (ul_state_q)
        PPR_UL_IDLE: begin
          ul_state_q <= (wr_osc && wr_low == `PPR_KEY_FIRST) ? PPR_UL_KEY1 : PPR_UL_IDLE;
        end
        PPR_UL_KEY1: begin
          if (wr_osc && wr_low == `PPR_KEY_SECOND) begin
            ul_state_q <= PPR_UL_KEY2;
          end else if (wr_osc && wr_low == `PPR_KEY_FIRST) begin
            ul_state_q <= PPR_UL_KEY1;
          end else begin
            ul_state_q <= PPR_UL_IDLE;
          end
        end
        default: begin
          ul_state_q <= PPR_UL_IDLE;
        end
      endcase
    end
  end

  // lock only moves on the write right after both keys
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= `PPR_LOCK_RESET;
    end else if (wr_osc && ul_state_q == PPR_UL_KEY2) begin
      if (!(one_way_sync_q[1] && lock_q)) begin
        lock_q <= hwdata[`PPR_OSC_LOCK_BIT];
      end
    end
  end

  always_comb begin
    map_write_lock = lock_q;
  end

  // map registers and their shadows; locked writes still answer okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_map_q[i] <= `PPR_IN_MAP_RESET;
        in_shadow_q[i] <= `PPR_IN_MAP_RESET;
      end
    end else if (wr_in && !lock_q) begin
      in_map_q[ap_q.idx[4:0]] <= wr_field;
      in_shadow_q[ap_q.idx[4:0]] <= wr_field;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        out_map_q[p] <= `PPR_OUT_MAP_RESET;
        out_shadow_q[p] <= `PPR_OUT_MAP_RESET;
      end
    end else if (wr_out && !lock_q) begin
      out_map_q[ap_q.idx[4:0]] <= wr_field;
      out_shadow_q[ap_q.idx[4:0]] <= wr_field;
    end
  end

  // shadows only differ if a map cell is disturbed
  always_comb begin
    mismatch = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      mismatch = mismatch | (in_map_q[i] != in_shadow_q[i]);
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      mismatch = mismatch | (out_map_q[p] != out_shadow_q[p]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_mismatch_reset <= 1'b0;
    end else begin
      cfg_mismatch_reset <= mismatch;
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // input side: one mux per peripheral input, no tie to output maps
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          periph_in[gi] <= 1'b0;
        end else if (in_map_q[gi] == `PPR_IN_GROUND || in_map_q[gi] >= NPIN5) begin
          periph_in[gi] <= 1'b0;
        end else begin
          periph_in[gi] <= pin_sync_q[in_map_q[gi]];
        end
      end
    end
  endgenerate

  // output side: the code indexes periph_out (0x11 drives low) and enables the pin; direction left to port logic for null and codes past 0x15
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_out
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_out[gp] <= 1'b0;
          pin_oe_n[gp] <= 1'b1;
        end else if (out_map_q[gp] == `PPR_OUT_NULL || out_map_q[gp] > `PPR_OUT_LAST) begin
          pin_out[gp] <= port_out[gp];
          pin_oe_n[gp] <= pin_direction_reg[gp];
        end else if (out_map_q[gp] == `PPR_OUT_UNUSED) begin
          pin_out[gp] <= 1'b0;
          pin_oe_n[gp] <= 1'b0;
        end else begin
          pin_out[gp] <= periph_out[out_map_q[gp]];
          pin_oe_n[gp] <= 1'b0;
        end
      end
    end
  endgenerate

  a_locked_in_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_in && lock_q |=> in_map_q[$past(ap_q.idx[4:0])] == $past(in_map_q[ap_q.idx[4:0]]))
    else $error("locked input map changed");
  a_open_in_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_in && !lock_q |=> in_map_q[$past(ap_q.idx[4:0])] == $past(hwdata[4:0]))
    else $error("unlocked input map write lost");
  a_lock_key_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_q != $past(lock_q) |-> $past(ul_state_q) == PPR_UL_KEY2 && $past(wr_osc))
    else $error("lock moved without keys");
  a_one_way_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    one_way_sync_q[1] && lock_q |=> lock_q)
    else $error("one-way lock cleared");
  a_key_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    ul_state_q == PPR_UL_KEY1 && wr_dphase && !wr_osc |=> ul_state_q == PPR_UL_IDLE)
    else $error("key sequence not abandoned");
  a_in_ground: assert property (@(posedge hclk) disable iff (!hresetn)
    in_map_q[0] == `PPR_IN_GROUND |=> !periph_in[0])
    else $error("ground code not grounding");
  a_in_route: assert property (@(posedge hclk) disable iff (!hresetn)
    in_map_q[0] == 5'h02 |=> periph_in[0] == $past(pin_sync_q[2]))
    else $error("input route wrong");
  a_out_null: assert property (@(posedge hclk) disable iff (!hresetn)
    out_map_q[0] == `PPR_OUT_NULL |=>
      pin_out[0] == $past(port_out[0]) && pin_oe_n[0] == $past(pin_direction_reg[0]))
    else $error("null code not port");
  a_out_uart: assert property (@(posedge hclk) disable iff (!hresetn)
    out_map_q[1] == 5'h03 |=> pin_out[1] == $past(periph_out[3]) && !pin_oe_n[1])
    else $error("uart code route wrong");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    ap_q.rd && !rd_done_q |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule
`default_nettype wire

// ---- logic/ppr_consts.svh ----
// constants for the peripheral pin remap block
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH
`define PPR_REGION_OSC 4'h0
`define PPR_REGION_IN 4'h1
`define PPR_REGION_OUT 4'h2
`define PPR_OSC_LOCK_BIT 6
`define PPR_KEY_FIRST 8'h46
`define PPR_KEY_SECOND 8'h57
`define PPR_LOCK_RESET 1'b0
`define PPR_IN_MAP_RESET 5'h1f
`define PPR_IN_GROUND 5'h1f
`define PPR_OUT_MAP_RESET 5'h00
`define PPR_OUT_NULL 5'h00
`define PPR_OUT_UNUSED 5'h11
`define PPR_OUT_LAST 5'h15
`define PPR_FIELD_W 5
`define PPR_MAX_PINS 26
`define PPR_MAX_INPUTS 32
`endif

// ---- logic/ppr_pkg.sv ----
// types for the peripheral pin remap block
`default_nettype none
package ppr_pkg;
  typedef enum logic [1:0] {
    PPR_UL_IDLE = 2'b00,
    PPR_UL_KEY1 = 2'b01,
    PPR_UL_KEY2 = 2'b10
  } ppr_unlock_t;

  // output selection codes; the code indexes periph_out directly, except PPR_O_NULL which leaves the pin to port logic and PPR_O_NONE which drives low
  typedef enum logic [4:0] {
    PPR_O_NULL = 5'h00, PPR_O_CMP1 = 5'h01, PPR_O_CMP2 = 5'h02,
    PPR_O_UART_ONE_TRANSMIT = 5'h03, PPR_O_UART_ONE_REQUEST_TO_SEND = 5'h04, PPR_O_UART_TWO_TRANSMIT = 5'h05, PPR_O_UART_TWO_REQUEST_TO_SEND = 5'h06,
    PPR_O_SPI1_DO = 5'h07, PPR_O_SPI1_CK = 5'h08, PPR_O_SPI1_SEL = 5'h09,
    PPR_O_SPI2_DO = 5'h0a, PPR_O_SPI2_CK = 5'h0b, PPR_O_SPI2_SEL = 5'h0c,
    PPR_O_CODEC_DO = 5'h0d, PPR_O_CODEC_CK = 5'h0e, PPR_O_CODEC_FS = 5'h0f,
    PPR_O_CAN_TX = 5'h10, PPR_O_NONE = 5'h11,
    PPR_O_CMP_OUT1 = 5'h12, PPR_O_CMP_OUT2 = 5'h13, PPR_O_CMP_OUT3 = 5'h14,
    PPR_O_CMP_OUT4 = 5'h15
  } ppr_out_code_t;

  typedef struct packed {
    logic [3:0] region;
    logic [5:0] idx;
    logic wr;
    logic rd;
  } ppr_aphase_t;
endpackage
`default_nettype wire

// ---- verification/ppr_periph_model.sv ----
// peripheral outputs and pin levels facing the remap block
`timescale 1ns/1ps
`default_nettype none
module ppr_periph_model (
  input wire logic [31:0] pat,
  input wire logic [25:0] pins,
  output logic [31:0] periph_out,
  output logic [25:0] pin_in,
  output logic [25:0] pin_direction_reg
);
  // pattern chosen per scenario so a wrong code picks a zero
  assign periph_out = pat;
  assign pin_in = pins;
  // pin 3 stays a port output, all others inputs for routing
  assign pin_direction_reg = ~26'h0000008;
endmodule
`default_nettype wire

// ---- verification/tb_ppr_remap.sv ----
// self-checking bench for the pin remap block
`timescale 1ns/1ps
`default_nettype none
module tb_ppr_remap import ppr_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic owl, lock, mis;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, pat, pout, rdv;
  logic [25:0] pins, pin_in, pin_out, oe_n, port_out, dir;
  logic [24:0] per_in;
  int fail_count;
  int num_checks;
  assign hready = hreadyout;
  ppr_remap i_ppr_remap (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .one_way_lock_option(owl), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(oe_n), .port_out(port_out),
    .pin_direction_reg(dir), .periph_out(pout), .periph_in(per_in),
    .map_write_lock(lock), .cfg_mismatch_reset(mis));
  ppr_periph_model i_ppr_periph_model (.pat(pat), .pins(pins),
    .periph_out(pout), .pin_in(pin_in), .pin_direction_reg(dir));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(n, e, rdv);
  endtask
  // mux outputs are flopped one edge after the register update
  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic lockw(input logic v);
    wr(32'h0, 32'h46);
    wr(32'h0, 32'h57);
    wr(32'h0, {25'h0, v, 6'h0});
    settle;
  endtask
  task automatic t_reset;
    chk("lock", 32'h0, 32'(lock));
    chk("per_in", 32'h0, 32'(per_in));
    rdc("in0", 32'h100, 32'h1f);
    rdc("out0", 32'h200, 32'h0);
    rdc("unmapped", 32'h300, 32'h0);
    rdc("in25", 32'h164, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_out;
    for (int c = 0; c < 22; c++) begin
      @(posedge hclk);
      pat <= 32'h1 << c;
      wr(32'h20c, c);
      settle;
      if (c == 0) begin
        chk("null", 32'(port_out[3]), 32'(pin_out[3]));
      end else begin
        chk("code", 32'(c != 17), 32'(pin_out[3]));
      end
      chk("oe", 32'h0, 32'(oe_n[3]));
    end
    $display("output code test done");
  endtask
  task automatic t_in;
    @(posedge hclk);
    pat <= 32'h8;
    wr(32'h12c, 32'h5);
    wr(32'h214, 32'h3);
    wr(32'h100, 32'h2);
    wr(32'h204, 32'h3);
    pins <= 26'h24;
    repeat (4) @(posedge hclk);
    #1;
    chk("in_hi", 32'h1, 32'(per_in[11]));
    chk("in0_hi", 32'h1, 32'(per_in[0]));
    chk("out5", 32'h1, 32'(pin_out[5]));
    chk("out1", 32'h1, 32'(pin_out[1]));
    chk("oe1", 32'h0, 32'(oe_n[1]));
    @(posedge hclk);
    pins <= 26'h0;
    repeat (4) @(posedge hclk);
    #1;
    chk("in_lo", 32'h0, 32'(per_in[11]));
    chk("in0_lo", 32'h0, 32'(per_in[0]));
    rdc("in11", 32'h12c, 32'h5);
    pins <= 26'h24;
    repeat (4) @(posedge hclk);
    #1;
    chk("in0_pre", 32'h1, 32'(per_in[0]));
    wr(32'h100, 32'h1f);
    repeat (4) @(posedge hclk);
    #1;
    chk("ground", 32'h0, 32'(per_in[0]));
    $display("input map test done");
  endtask
  task automatic t_lock;
    lockw(1'b1);
    chk("lock_set", 32'h1, 32'(lock));
    rdc("osc", 32'h0, 32'h40);
    wr(32'h12c, 32'h7);
    rdc("locked", 32'h12c, 32'h5);
    wr(32'h0, 32'h46);
    wr(32'h200, 32'h0);
    wr(32'h0, 32'h57);
    wr(32'h0, 32'h0);
    settle;
    chk("abort", 32'h1, 32'(lock));
    lockw(1'b0);
    chk("lock_clr", 32'h0, 32'(lock));
    wr(32'h12c, 32'h9);
    wr(32'h130, 32'h2);
    rdc("open1", 32'h12c, 32'h9);
    rdc("open2", 32'h130, 32'h2);
    $display("lock test done");
  endtask
  task automatic t_oneway;
    owl <= 1'b1;
    repeat (3) @(posedge hclk);
    lockw(1'b1);
    lockw(1'b0);
    chk("oneway", 32'h1, 32'(lock));
    chk("mismatch", 32'h0, 32'(mis));
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_lock", 32'h0, 32'(lock));
    hresetn <= 1'b1;
    owl <= 1'b0;
    rdc("rst_in11", 32'h12c, 32'h1f);
    $display("one-way test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge hclk);
    fail_count++;
    close_out;
  end
  initial begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    owl <= 1'b0;
    pat <= 32'h0;
    pins <= 26'h0;
    port_out <= 26'h2aaaaaa;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_out;
    t_in;
    t_lock;
    t_oneway;
    close_out;
  end
endmodule
`default_nettype wire
